// File: prit_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module prit_arbiter (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // requests and grant
    input  wire prit_pkg::prit_req_t req,
    output var  prit_pkg::prit_req_t grant
);
    import prit_pkg::*;

    // ------------------------------------------------------------
    // fixed priority grant
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            grant <= '0;
        end else begin
            grant <= '0;
            if (req.ext_master)   grant.ext_master <= 1'b1;
            else if (req.refresh) grant.refresh    <= 1'b1;
            else if (req.dma)     grant.dma        <= 1'b1;
            else if (req.cpu)     grant.cpu        <= 1'b1;
        end
    end

    AST_EXT_FIRST: assert property (@(posedge clock) disable iff (reset)
        req.ext_master |=> grant.ext_master && !grant.refresh && !grant.cpu)
        else $error("external master not granted first");
    AST_REFRESH_STROBE_SECOND: assert property (@(posedge clock) disable iff (reset)
        req.refresh && !req.ext_master |=> grant.refresh)
        else $error("refresh not granted ahead of dma and cpu");
endmodule : prit_arbiter
`default_nettype wire

// File: prit_pkg.sv
package prit_pkg;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          PRIT_CNT_W      = 8;
    localparam logic [7:0]  PRIT_CNT_RST    = 8'h00;
    localparam logic [7:0]  PRIT_COR_RST    = 8'hff;
    localparam logic [2:0]  PRIT_CKS_RST    = 3'h0;
    localparam int          PRIT_PRE_W      = 12;
    // prescaler taps per clock select code, code 0 means halted
    localparam int          PRIT_TAP_1      = 0;
    localparam int          PRIT_TAP_2      = 2;
    localparam int          PRIT_TAP_3      = 4;
    localparam int          PRIT_TAP_4      = 6;
    localparam int          PRIT_TAP_5      = 8;
    localparam int          PRIT_TAP_6      = 10;
    localparam int          PRIT_TAP_7      = 11;
    // refresh and memory cycle lengths in states, shared by dram and psram
    localparam logic [2:0]  PRIT_REFRESH_STROBE_STATES = 3'h3;
    localparam logic [2:0]  PRIT_MEM_STATES  = 3'h3;

    // bus requesters in priority order
    typedef struct packed {
        logic ext_master;
        logic refresh;
        logic dma;
        logic cpu;
    } prit_req_t;

    // software view of the control/status bits
    typedef struct packed {
        logic       dynamic_ram_enable;
        logic       pseudo_static_enable;
        logic       self_refresh_select;
        logic       match_irq_enable;
        logic [2:0] prescaler_clock_select;
    } prit_cfg_t;

    // memory strobe set, active low levels and output enables
    typedef struct packed {
        logic area3_select_n;
        logic refresh_strobe_n;
        logic read_strobe_n;
        logic upper_write_strobe_n;
        logic lower_write_strobe_n;
        logic strobe_oe;
    } prit_pins_t;
endpackage : prit_pkg

// File: prit_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module prit_prescaler (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // select and pulse
    input  wire logic [2:0] sel,
    output logic            tick
);
    import prit_pkg::*;

    logic [PRIT_PRE_W-1:0] div_r;
    logic                  src;
    logic                  src_r;

    // ------------------------------------------------------------
    // free running divider
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) div_r <= '0;
        else       div_r <= div_r + 1'b1;
    end

    // selected source, code 0 halts it low
    always_comb begin
        case (sel)
            3'h1:    src = div_r[PRIT_TAP_1];
            3'h2:    src = div_r[PRIT_TAP_2];
            3'h3:    src = div_r[PRIT_TAP_3];
            3'h4:    src = div_r[PRIT_TAP_4];
            3'h5:    src = div_r[PRIT_TAP_5];
            3'h6:    src = div_r[PRIT_TAP_6];
            3'h7:    src = div_r[PRIT_TAP_7];
            default: src = 1'b0;
        endcase
    end

    // falling edge of the muxed source; high to low switch counts too
    always_ff @(posedge clock) begin
        if (reset) src_r <= 1'b0;
        else       src_r <= src;
    end
    assign tick = src_r && !src;
endmodule : prit_prescaler
`default_nettype wire

// File: prit_psram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// pseudo-static ram chips on area 3, watching the strobes
// ------------------------------------------------------------
module prit_psram_model (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset,
    // memory pins
    input  wire prit_pkg::prit_pins_t pins,
    // observed refresh activity
    output int                        refresh_count,
    output int                        low_len
);
    import prit_pkg::*;
    logic prev_n;
    int   run;

    // count refresh strobes and measure each low pulse
    always_ff @(posedge clock) begin
        if (reset) begin
            refresh_count <= 0;
            low_len       <= 0;
            run           <= 0;
            prev_n        <= 1'b1;
        end else begin
            prev_n <= pins.refresh_strobe_n;
            // a driven falling strobe is one refresh cycle
            if (pins.strobe_oe && prev_n && !pins.refresh_strobe_n)
                refresh_count <= refresh_count + 1;
            // pulse length in states
            if (!pins.refresh_strobe_n)
                run <= run + 1;
            else begin
                if (run != 0)
                    low_len <= run;
                run <= 0;
            end
        end
    end
endmodule : prit_psram_model
`default_nettype wire

// File: prit_refresh_timer.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - psram refresh spaced by compare and prescaler
// - psram cycles use dram state counts
// - grant order: external, refresh, dma, cpu
// - wait states stretch bus and refresh cycles
// - self-refresh standby: select high, refresh low
// - standby psram: strobes float, select high
// - runs in sleep; standby clears counter and flags
// - both enables clear selects interval timer
// - match flag set as counter leaves match
// - standby clears count and flags, keeps settings
// - clear beats counter write in T3
// - counter write beats increment in T3
// - compare write in T3 suppresses match
// - counter clock from falling selected edge
// - match interrupt gated by enable bit
// - guard refresh and select low together
// - no refresh while released, standby, waiting
// - released requests collapse to one refresh
// - waited cycle holds first refresh request
// - standby with release enabled may glitch
// - first request sets flag, no refresh
module prit_refresh_timer (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset,
    // power state
    input  wire logic                  soft_standby,
    input  wire logic                  hard_standby,
    // software configuration
    input  wire prit_pkg::prit_cfg_t   cfg,
    input  wire logic                  area3_access_states,
    input  wire logic                  bus_release_enable,
    // counter and compare writes, strobed in the T3 state
    input  wire logic                  count_wr,
    input  wire logic [7:0]            count_wdata,
    input  wire logic                  compare_wr,
    input  wire logic [7:0]            compare_wdata,
    input  wire logic                  flag_clear,
    input  wire logic                  flag_read,
    // other bus requests and cycle status
    input  wire logic                  ext_bus_req,
    input  wire logic                  dma_req,
    input  wire logic                  cpu_req,
    input  wire logic                  wait_req,
    input  wire logic                  cpu_mem_cycle,
    input  wire logic                  cpu_mem_write,
    // status and grant
    output logic [7:0]                 refresh_timer_count,
    output logic [7:0]                 refresh_compare_value,
    output logic                       match_flag,
    output logic                       match_interrupt,
    output prit_pkg::prit_req_t        bus_grant,
    output logic                       bus_released,
    // memory pins
    output prit_pkg::prit_pins_t       pins
);
    import prit_pkg::*;

    default clocking prit_cb @(posedge clock);
    endclocking
    default disable iff (reset);

    typedef enum {PRIT_IDLE, PRIT_REFRESH_STROBE, PRIT_MEM} prit_state_t;

    logic        tick;
    logic        run;
    logic        mem_en;
    logic        match_pulse;
    logic        pend_r;
    logic        first_r;
    logic        flag_seen_r;
    logic        refresh_strobe_cycle;
    logic [2:0]  st_cnt_r;
    logic [2:0]  cks_r;
    logic        sr_active;
    prit_state_t state_r;
    prit_req_t   req;
    prit_req_t   grant;

    assign mem_en = cfg.dynamic_ram_enable || cfg.pseudo_static_enable;
    // the timer stops in hardware standby and in software standby; sleep keeps it running
    assign run    = !hard_standby && !soft_standby;
    assign sr_active = soft_standby && cfg.pseudo_static_enable
                       && cfg.self_refresh_select;

    // ------------------------------------------------------------
    // prescaler and arbiter
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) cks_r <= PRIT_CKS_RST;
        else       cks_r <= cfg.prescaler_clock_select; // kept across standby
    end

    prit_prescaler u_pre (
        .clock (clock),
        .reset (reset),
        .sel   (run ? cks_r : 3'h0),
        .tick  (tick)
    );

    // requests into the arbiter, one driver for the whole word
    assign req = '{ext_master: ext_bus_req && bus_release_enable,
                   refresh:    pend_r && !first_r && mem_en && !wait_req && !soft_standby,
                   dma:        dma_req,
                   cpu:        cpu_req};

    prit_arbiter u_arb (
        .clock (clock),
        .reset (reset),
        .req   (req),
        .grant (grant)
    );

    // ------------------------------------------------------------
    // counter and compare value
    // ------------------------------------------------------------
    // match leaves on the tick that advances past the compare value
    assign match_pulse = run && tick && (refresh_timer_count == refresh_compare_value)
                         && !compare_wr;

    always_ff @(posedge clock) begin
        if (reset || soft_standby || hard_standby) begin
            refresh_timer_count <= PRIT_CNT_RST;
        end else if (match_pulse) begin
            refresh_timer_count <= PRIT_CNT_RST;
        end else if (count_wr) begin
            refresh_timer_count <= count_wdata;
        end else if (tick) begin
            refresh_timer_count <= refresh_timer_count + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (reset)           refresh_compare_value <= PRIT_COR_RST;
        else if (compare_wr) refresh_compare_value <= compare_wdata;
    end

    // ------------------------------------------------------------
    // match flag and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset || soft_standby) begin
            flag_seen_r <= 1'b0;
        end else if (flag_read && match_flag) begin
            flag_seen_r <= 1'b1;
        end else if (flag_clear) begin
            flag_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || soft_standby) begin
            match_flag <= 1'b0;
        end else if (match_pulse) begin
            match_flag <= 1'b1;
        end else if (flag_clear && flag_seen_r) begin
            match_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || soft_standby) match_interrupt <= 1'b0;
        else match_interrupt <= cfg.match_irq_enable && (match_flag || match_pulse);
    end

    // ------------------------------------------------------------
    // pending refresh request
    // ------------------------------------------------------------
    // first match after reset or standby is only a flag
    always_ff @(posedge clock) begin
        if (reset || soft_standby || hard_standby) begin
            first_r <= 1'b1;
        end else if (match_pulse) begin
            first_r <= 1'b0;
        end
    end

    // one held request; more matches while released or waiting merge into it
    always_ff @(posedge clock) begin
        if (reset || soft_standby || !mem_en) begin
            pend_r <= 1'b0;
        end else if (match_pulse && !first_r) begin
            pend_r <= 1'b1;
        end else if (grant.refresh) begin
            pend_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset || soft_standby) begin
            state_r  <= PRIT_IDLE;
            st_cnt_r <= 3'h0;
        end else begin
            case (state_r)
                PRIT_IDLE: begin
                    if (grant.refresh) begin
                        state_r  <= PRIT_REFRESH_STROBE;
                        st_cnt_r <= PRIT_REFRESH_STROBE_STATES;
                    end else if (grant.cpu && cpu_mem_cycle) begin
                        state_r  <= PRIT_MEM;
                        st_cnt_r <= PRIT_MEM_STATES;
                    end
                end
                PRIT_REFRESH_STROBE, PRIT_MEM: begin
                    if (!(area3_access_states && wait_req)) begin
                        if (st_cnt_r == 3'h1) state_r <= PRIT_IDLE;
                        st_cnt_r <= st_cnt_r - 3'h1;
                    end
                end
                default: state_r <= PRIT_IDLE;
            endcase
        end
    end

    assign refresh_strobe_cycle = (state_r == PRIT_REFRESH_STROBE);

    // ------------------------------------------------------------
    // registered pins and grant
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            pins         <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            bus_grant    <= '0;
            bus_released <= 1'b0;
        end else begin
            bus_grant    <= grant;
            bus_released <= grant.ext_master;
            if (soft_standby && mem_en) begin
                // a one state release before standby is not filtered here
                pins.area3_select_n       <= 1'b1;
                pins.refresh_strobe_n     <= !sr_active;
                pins.read_strobe_n        <= 1'b1;
                pins.upper_write_strobe_n <= 1'b1;
                pins.lower_write_strobe_n <= 1'b1;
                pins.strobe_oe            <= 1'b0;
            end else if (!mem_en) begin
                // idle strobes high so both cannot sit low at once
                pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            end else begin
                pins.strobe_oe            <= !grant.ext_master;
                pins.refresh_strobe_n     <= !refresh_strobe_cycle;
                pins.area3_select_n       <= !(state_r == PRIT_MEM) || refresh_strobe_cycle;
                pins.read_strobe_n        <= !(state_r == PRIT_MEM && !cpu_mem_write);
                pins.upper_write_strobe_n <= !(state_r == PRIT_MEM && cpu_mem_write);
                pins.lower_write_strobe_n <= !(state_r == PRIT_MEM && cpu_mem_write);
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_NO_DUAL_LOW: assert property (@(posedge clock) disable iff (reset)
        !(!pins.refresh_strobe_n && !pins.area3_select_n))
        else $error("refresh strobe and select low together");
    AST_SELF_REFRESH: assert property (@(posedge clock) disable iff (reset)
        sr_active && mem_en |=> pins.area3_select_n && !pins.refresh_strobe_n)
        else $error("self-refresh pin levels wrong");
    AST_STANDBY_FLOAT: assert property (@(posedge clock) disable iff (reset)
        soft_standby && mem_en |=> !pins.strobe_oe)
        else $error("strobes driven in standby");
    AST_MATCH_SETS_FLAG: assert property (@(posedge clock) disable iff (reset)
        match_pulse && !soft_standby |=> match_flag && refresh_timer_count == 8'h00)
        else $error("match did not set flag and zero count");
    AST_WRITE_BEATS_INC: assert property (@(posedge clock) disable iff (reset)
        count_wr && tick && !match_pulse && run |=> refresh_timer_count == $past(count_wdata))
        else $error("counter write lost to increment");
    AST_COR_WRITE_INHIBIT: assert property (@(posedge clock) disable iff (reset)
        compare_wr && run && tick && !count_wr
            && refresh_timer_count == refresh_compare_value
        |=> refresh_timer_count == $past(refresh_timer_count) + 8'h01)
        else $error("match during compare write");
    AST_STANDBY_CLEARS: assert property (@(posedge clock) disable iff (reset)
        soft_standby |=> refresh_timer_count == 8'h00 && !match_flag)
        else $error("standby did not clear counter and flag");
    AST_FIRST_NO_REFRESH: assert property (@(posedge clock) disable iff (reset)
        first_r && match_pulse |=> !pend_r)
        else $error("first request started refresh");
    AST_NO_REFRESH_STROBE_RELEASED: assert property (@(posedge clock) disable iff (reset)
        grant.ext_master |-> !grant.refresh)
        else $error("refresh while bus released");
    AST_IRQ_GATED: assert property (@(posedge clock) disable iff (reset)
        !cfg.match_irq_enable |=> !match_interrupt)
        else $error("interrupt raised while masked");

    // ------------------------------------------------------------
    // checks on standby, waits and cycle timing
    // ------------------------------------------------------------
    // a clear wins over a counter write in the same state
    AST_CLEAR_BEATS_WRITE: assert property (
        match_pulse && count_wr
        |=> refresh_timer_count == 8'h00)
        else $error("counter write beat the clear");

    // hardware standby holds the counter at zero
    AST_HARD_HALT: assert property (
        hard_standby
        |=> refresh_timer_count == 8'h00)
        else $error("counter ran in hardware standby");

    // waits keep a refresh request off the bus
    AST_WAIT_NO_GRANT: assert property (
        wait_req
        |=> !grant.refresh)
        else $error("refresh granted during waits");

    // waits freeze the state count of a running cycle
    AST_WAIT_STRETCH: assert property (
        state_r != PRIT_IDLE && area3_access_states && wait_req && !soft_standby
        |=> $stable(st_cnt_r))
        else $error("wait did not stretch the cycle");

    // a granted refresh loads the shared state count
    AST_REFRESH_STROBE_LEN: assert property (
        grant.refresh && state_r == PRIT_IDLE && !soft_standby
        |=> refresh_strobe_cycle && st_cnt_r == PRIT_REFRESH_STROBE_STATES)
        else $error("refresh cycle length wrong");

    // memory off leaves select and refresh high
    AST_OFF_STROBES: assert property (
        !mem_en
        |=> pins.area3_select_n && pins.refresh_strobe_n)
        else $error("strobes low with memory off");

    // a held request survives the release
    AST_HOLD_RELEASED: assert property (
        pend_r && grant.ext_master && mem_en && !soft_standby
        |=> pend_r)
        else $error("held refresh request lost");

    // an external grant shows as released next cycle
    AST_RELEASED_FLAG: assert property (
        grant.ext_master
        |=> bus_released)
        else $error("released state not shown");
endmodule : prit_refresh_timer
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import prit_pkg::*;
    logic       clock, reset, soft_standby, hard_standby, area3_access_states;
    logic       bus_release_enable, count_wr, compare_wr, flag_clear, flag_read;
    logic       ext_bus_req, dma_req, cpu_req, wait_req, cpu_mem_cycle, cpu_mem_write;
    logic       match_flag, match_interrupt, bus_released;
    logic [7:0] count_wdata, compare_wdata, refresh_timer_count, refresh_compare_value;
    logic [7:0] lfsr_r, model_cor, wd;
    prit_cfg_t  cfg;
    prit_req_t  bus_grant, exp_g;
    prit_pins_t pins;
    int         refresh_count, low_len, errors, cmp_count, cycles, base, i;

    prit_refresh_timer prit_refresh_timer_i (.clock(clock), .reset(reset),
        .soft_standby(soft_standby), .hard_standby(hard_standby), .cfg(cfg),
        .area3_access_states(area3_access_states), .bus_release_enable(bus_release_enable),
        .count_wr(count_wr), .count_wdata(count_wdata), .compare_wr(compare_wr),
        .compare_wdata(compare_wdata), .flag_clear(flag_clear), .flag_read(flag_read),
        .ext_bus_req(ext_bus_req), .dma_req(dma_req), .cpu_req(cpu_req), .wait_req(wait_req),
        .cpu_mem_cycle(cpu_mem_cycle), .cpu_mem_write(cpu_mem_write),
        .refresh_timer_count(refresh_timer_count), .refresh_compare_value(refresh_compare_value),
        .match_flag(match_flag), .match_interrupt(match_interrupt), .bus_grant(bus_grant),
        .bus_released(bus_released), .pins(pins));

    prit_psram_model prit_psram_model_i (.clock(clock), .reset(reset), .pins(pins),
        .refresh_count(refresh_count), .low_len(low_len));

    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // cut a hang short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask : step

    task automatic wr_cnt(input logic [7:0] v);
        count_wdata <= v;
        count_wr    <= 1'b1;
        step(1);
        count_wr    <= 1'b0;
        step(1);
        chk("count write", refresh_timer_count, v);
    endtask : wr_cnt

    task automatic wr_cor(input logic [7:0] v);
        model_cor      = v;
        compare_wdata <= v;
        compare_wr    <= 1'b1;
        step(1);
        compare_wr    <= 1'b0;
        step(1);
        chk("compare write", refresh_compare_value, model_cor);
    endtask : wr_cor

    task automatic wait_flag;
        int k;
        k = 0;
        while (match_flag !== 1'b1 && k < 400) begin
            step(1);
            k++;
        end
        chk("flag wait", match_flag, 1'b1);
    endtask : wait_flag

    task automatic clear_flag;
        flag_read  <= 1'b1;
        step(1);
        flag_read  <= 1'b0;
        flag_clear <= 1'b1;
        step(1);
        flag_clear <= 1'b0;
        step(2);
    endtask : clear_flag

    task automatic final_report;
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {soft_standby, hard_standby, count_wr, compare_wr, flag_clear, flag_read} = '0;
        {ext_bus_req, dma_req, cpu_req, wait_req, cpu_mem_cycle, cpu_mem_write} = '0;
        {count_wdata, compare_wdata} = '0;
        area3_access_states = 1'b1;
        bus_release_enable  = 1'b1;
        cfg       = '0;
        reset     = 1'b1;
        lfsr_r    = 8'h3d;
        model_cor = PRIT_COR_RST;
        step(5);
        reset <= 1'b0;
        step(2);
        // reset state
        chk("count reset", refresh_timer_count, PRIT_CNT_RST);
        chk("compare reset", refresh_compare_value, PRIT_COR_RST);
        chk("flag reset", {match_flag, match_interrupt}, 2'h0);
        chk("pins reset", pins, 6'h3f);
        // counter writes while the counter is running
        cfg <= '{1'b0, 1'b0, 1'b0, 1'b0, 3'h1};
        for (i = 0; i < 4; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            wd     = lfsr_r & 8'h7f;
            wr_cnt(wd);
        end
        // interval timer with interrupt
        wr_cor(8'h05);
        wr_cnt(8'h00);
        cfg <= '{1'b0, 1'b0, 1'b0, 1'b1, 3'h1};
        wait_flag();
        chk("count after match", refresh_timer_count, 8'h00);
        chk("irq enabled", match_interrupt, 1'b1);
        cfg <= '{1'b0, 1'b0, 1'b0, 1'b0, 3'h0};
        step(3);
        chk("irq masked", match_interrupt, 1'b0);
        clear_flag();
        chk("flag cleared", match_flag, 1'b0);
        wr_cnt(8'h10);
        step(10);
        chk("halted count", refresh_timer_count, 8'h10);
        hard_standby <= 1'b1;
        step(3);
        chk("hard standby count", refresh_timer_count, 8'h00);
        hard_standby <= 1'b0;
        // software standby clears count and status, keeps settings
        cfg <= '{1'b0, 1'b0, 1'b0, 1'b1, 3'h1};
        wait_flag();
        soft_standby <= 1'b1;
        step(3);
        chk("standby count", refresh_timer_count, 8'h00);
        chk("standby flags", {match_flag, match_interrupt}, 2'h0);
        chk("standby compare", refresh_compare_value, model_cor);
        soft_standby <= 1'b0;
        step(2);
        // pseudo-static standby pins with and without self refresh
        for (i = 1; i >= 0; i--) begin
            cfg <= '{1'b0, 1'b1, i[0], 1'b0, 3'h0};
            step(2);
            soft_standby <= 1'b1;
            step(3);
            chk("standby select", pins.area3_select_n, 1'b1);
            chk("standby refresh", pins.refresh_strobe_n, !i[0]);
            chk("standby float", pins.strobe_oe, 1'b0);
            soft_standby <= 1'b0;
            step(3);
            chk("resume refresh", pins.refresh_strobe_n, 1'b1);
        end
        // refresh spacing, first request skipped
        wr_cor(8'h03);
        cfg  <= '{1'b0, 1'b1, 1'b0, 1'b0, 3'h1};
        base  = refresh_count;
        wait_flag();
        step(6);
        chk("first request", refresh_count, base);
        clear_flag();
        step(80);
        chk("refreshes run", refresh_count > base, 1'b1);
        chk("refresh length", low_len, PRIT_REFRESH_STROBE_STATES);
        // released bus holds one request
        cfg <= '{1'b0, 1'b1, 1'b0, 1'b0, 3'h3};
        ext_bus_req <= 1'b1;
        step(300);
        clear_flag();
        base = refresh_count;
        wait_flag();
        step(4);
        chk("released", bus_released, 1'b1);
        chk("no refresh released", refresh_count, base);
        ext_bus_req <= 1'b0;
        step(10);
        chk("one held refresh", refresh_count, base + 1);
        // arbiter priority over every mix of external, dma and cpu requests
        cfg <= '0;
        step(4);
        for (i = 1; i < 8; i++) begin
            {ext_bus_req, dma_req, cpu_req} <= i[2:0];
            cpu_mem_cycle <= i[0];
            step(4);
            exp_g = '0;
            if (i[2])
                exp_g.ext_master = 1'b1;
            else if (i[1])
                exp_g.dma = 1'b1;
            else
                exp_g.cpu = 1'b1;
            chk("grant", bus_grant, exp_g);
            {ext_bus_req, dma_req, cpu_req, cpu_mem_cycle} <= 4'h0;
            step(4);
        end
        final_report();
    end
endmodule : testbench
`default_nettype wire
